/* File: count_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none

module count_pin_model #(
  parameter int HOLD = 12
) (
  input  wire logic clk,
  output logic      timer0_count_input,
  output logic      timer1_count_input,
  output logic      ext_irq0_pin,
  output logic      ext_irq1_pin
);
  // pins rest high, as the port pull-ups hold them between events
  initial
  begin
    timer0_count_input = 1'b1;
    timer1_count_input = 1'b1;
    ext_irq0_pin       = 1'b1;
    ext_irq1_pin       = 1'b1;
  end

  // n falls on one count pin; each level lasts HOLD clocks so the sampler cannot miss it
  task automatic pulse(input int which, input int n);
    repeat (n)
    begin
      @(posedge clk);
      if (which == 0) timer0_count_input <= 1'b0;
      else timer1_count_input <= 1'b0;
      repeat (HOLD) @(posedge clk);
      if (which == 0) timer0_count_input <= 1'b1;
      else timer1_count_input <= 1'b1;
      repeat (HOLD) @(posedge clk);
    end
  endtask

  // move one interrupt pin to a new level just after an edge
  task automatic irq(input int which, input logic lvl);
    @(posedge clk);
    if (which == 0) ext_irq0_pin <= lvl;
    else ext_irq1_pin <= lvl;
  endtask
endmodule

`default_nettype wire

/* File: dtc_pkg.sv */
package dtc_pkg;

  // counting arrangement of one timer
  typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD, MODE_SPLIT} timer_mode_t;

  // result of one counting step
  typedef struct packed {
    logic       ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } timer_step_t;

  // vector acknowledge pulses from the interrupt controller
  typedef struct packed {
    logic tf1;
    logic tf0;
    logic ie1;
    logic ie0;
  } vector_ack_t;

  // request flags toward the interrupt controller
  typedef struct packed {
    logic tf1;
    logic tf0;
    logic ie1;
    logic ie0;
  } irq_flags_t;

endpackage

/* File: dtc_regs.svh */
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

// register addresses on the special function register port
`define DTC_ADDR_CONTROL      8'h88
`define DTC_ADDR_MODE         8'h89
`define DTC_ADDR_T0_LOW       8'h8A
`define DTC_ADDR_T1_LOW       8'h8B
`define DTC_ADDR_T0_HIGH      8'h8C
`define DTC_ADDR_T1_HIGH      8'h8D

// reset values
`define DTC_CONTROL_RESET     8'h00
`define DTC_MODE_RESET        8'h00
`define DTC_COUNT_RESET       8'h00

// timer_control bit positions
`define DTC_TF1_BIT           7
`define DTC_TR1_BIT           6
`define DTC_TF0_BIT           5
`define DTC_TR0_BIT           4
`define DTC_IE1_BIT           3
`define DTC_IT1_BIT           2
`define DTC_IE0_BIT           1
`define DTC_IT0_BIT           0

// timer_mode_config bit positions (mode field is two bits wide)
`define DTC_GATE1_BIT         7
`define DTC_CT1_BIT           6
`define DTC_MODE1_LSB         4
`define DTC_GATE0_BIT         3
`define DTC_CT0_BIT           2
`define DTC_MODE0_LSB         0

// one machine cycle in core clock periods
`define DTC_MC_CLOCKS         12

`endif

/* File: dual_timer_counter_control.sv */
// Operation
// RULE1: gate set: count only with run and pin high
// RULE2: gate clear: count whenever run bit set
// RULE3: counter select set: count external pin falls
// RULE4: counter select clear: count internal machine cycles
// RULE5: mode 00: 8-bit counter after 5-bit prescaler
// RULE6: mode 01: one cascaded 16-bit counter
// RULE7: mode 10: low byte reloads from high byte
// RULE8: timer 1 in mode 11 holds its count
// RULE9: timer 0 mode 11: two split 8-bit counters
// RULE10: overflow sets the timer overflow flag
// RULE11: vectoring clears the timer overflow flag
// RULE12: run bit one runs, zero stops timer
// RULE13: pin edge or low level sets interrupt flag
// RULE14: edge flag cleared on vector; level follows pin
// RULE15: trigger bit one edge, zero low level
// RULE16: interrupt bits never affect timer counting
// RULE17: control register is zero after reset
// RULE18: count kept in two 8-bit byte registers
// RULE19: timer function advances once per machine cycle
// RULE20: count pin sampled per machine cycle, high-low
// RULE21: mode 00 counts 13 bits, upper three untouched
// RULE22: reload leaves the high byte unchanged
// RULE23: hardware set beats same-cycle software clear
`timescale 1ns/1ps
`default_nettype none
`include "dtc_regs.svh"

module dual_timer_counter_control #(
  parameter int unsigned MC_CLOCKS = `DTC_MC_CLOCKS
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic [7:0]          sfr_addr,
  input  wire logic                sfr_wr_en,
  input  wire logic [7:0]          sfr_wdata,
  input  wire logic                sfr_rd_en,
  output logic      [7:0]          sfr_rdata,
  input  wire logic                ext_irq0_pin,
  input  wire logic                ext_irq1_pin,
  input  wire logic                timer0_count_input,
  input  wire logic                timer1_count_input,
  input  wire dtc_pkg::vector_ack_t vector_ack,
  output dtc_pkg::irq_flags_t      irq_flags
);
  import dtc_pkg::*;

  // one counting step of a timer in modes 00, 01, 10 and the low half of 11
  function automatic timer_step_t step(input timer_mode_t m, input logic [7:0] lo,
                                       input logic [7:0] hi, input logic inc);
    timer_step_t r;
    r = '{ovf: 1'b0, hi: hi, lo: lo};
    if (inc)
    begin
      unique case (m)
        MODE_13BIT:  {r.ovf, r.hi, r.lo[4:0]} = {1'b0, hi, lo[4:0]} + 14'd1; // see RULE5 see RULE21
        MODE_16BIT:  {r.ovf, r.hi, r.lo} = {1'b0, hi, lo} + 17'd1;           // see RULE6
        MODE_RELOAD:
        begin
          {r.ovf, r.lo} = {1'b0, lo} + 9'd1;
          if (r.ovf)
            r.lo = hi;                                                      // see RULE7 see RULE22
        end
        MODE_SPLIT:  {r.ovf, r.lo} = {1'b0, lo} + 9'd1;                      // see RULE9
      endcase
    end
    return r;
  endfunction

  // software visible registers
  logic [7:0] timer_control_reg;   // timer_control, assembled from the bits below
  // one flop per control bit, so each concern below is the only writer of its bits
  logic       tf1_reg, tr1_reg, tf0_reg, tr0_reg;
  logic       ie1_reg, it1_reg, ie0_reg, it0_reg;
  logic [7:0] timer_mode_config_reg;   // timer_mode_config
  logic [7:0] tl0_reg;    // timer0_low_byte
  logic [7:0] th0_reg;    // timer0_high_byte
  logic [7:0] tl1_reg;    // timer1_low_byte
  logic [7:0] th1_reg;    // timer1_high_byte
  assign timer_control_reg = {tf1_reg, tr1_reg, tf0_reg, tr0_reg, ie1_reg, it1_reg, ie0_reg, it0_reg};

  // machine cycle pulse and sampled pins: [0] irq0, [1] irq1, [2] t0, [3] t1
  logic       mc_tick;
  logic [3:0] pin_level;
  logic [3:0] pin_fall;
  logic [1:0] irq_level_d_reg;  // last clock's synchronised irq levels

  machine_cycle_gen #(
    .MC_CLOCKS (MC_CLOCKS)
  ) u_mc (
    .clk     (clk),
    .reset_n (reset_n),
    .mc_tick (mc_tick)
  );

  pin_sampler #(
    .W (4)
  ) u_pins (
    .clk     (clk),
    .reset_n (reset_n),
    .mc_tick (mc_tick),
    .pin     ({timer1_count_input, timer0_count_input, ext_irq1_pin, ext_irq0_pin}),
    .level   (pin_level),
    .fall    (pin_fall)
  );

  // decoded mode fields
  timer_mode_t mode0;
  timer_mode_t mode1;
  assign mode0 = timer_mode_t'(timer_mode_config_reg[`DTC_MODE0_LSB +: 2]);
  assign mode1 = timer_mode_t'(timer_mode_config_reg[`DTC_MODE1_LSB +: 2]);

  // write strobes per register
  logic wr_timer_control;
  logic wr_timer_mode_config;
  logic wr_tl0;
  logic wr_th0;
  logic wr_tl1;
  logic wr_th1;
  assign wr_timer_control = sfr_wr_en && (sfr_addr == `DTC_ADDR_CONTROL);
  assign wr_timer_mode_config = sfr_wr_en && (sfr_addr == `DTC_ADDR_MODE);
  assign wr_tl0  = sfr_wr_en && (sfr_addr == `DTC_ADDR_T0_LOW);
  assign wr_th0  = sfr_wr_en && (sfr_addr == `DTC_ADDR_T0_HIGH);
  assign wr_tl1  = sfr_wr_en && (sfr_addr == `DTC_ADDR_T1_LOW);
  assign wr_th1  = sfr_wr_en && (sfr_addr == `DTC_ADDR_T1_HIGH);

  // count source: pin falls in counter function, machine cycles otherwise
  logic src0;
  logic src1;
  assign src0 = timer_mode_config_reg[`DTC_CT0_BIT] ? pin_fall[2] : mc_tick; // see RULE3 see RULE4 see RULE20
  assign src1 = timer_mode_config_reg[`DTC_CT1_BIT] ? pin_fall[3] : mc_tick; // see RULE3 see RULE4 see RULE20

  // run enables; the interrupt flag and trigger bits take no part here
  logic run0;
  logic run1;
  assign run0 = timer_control_reg[`DTC_TR0_BIT] && (!timer_mode_config_reg[`DTC_GATE0_BIT] || pin_level[0]); // see RULE1 see RULE2 see RULE12 see RULE16
  assign run1 = timer_control_reg[`DTC_TR1_BIT] && (!timer_mode_config_reg[`DTC_GATE1_BIT] || pin_level[1]) // see RULE1 see RULE2 see RULE12
                && (mode1 != MODE_SPLIT);                                               // see RULE8

  // next byte values
  timer_step_t t0_step;
  timer_step_t t1_step;
  logic        th0_split_inc;
  logic        th0_split_ovf;
  logic [7:0]  th0_split_val;
  assign t0_step       = step(mode0, tl0_reg, th0_reg, run0 && src0);
  assign t1_step       = step(mode1, tl1_reg, th1_reg, run1 && src1);
  // split high byte is a machine-cycle timer run by timer 1's run bit
  assign th0_split_inc = (mode0 == MODE_SPLIT) && timer_control_reg[`DTC_TR1_BIT] && mc_tick; // see RULE9
  assign {th0_split_ovf, th0_split_val} = {1'b0, th0_reg} + 9'd1;

  // overflow events feeding the two timer flags
  logic ovf0_evt;
  logic ovf1_evt;
  assign ovf0_evt = t0_step.ovf;
  // in split mode the high byte of timer 0 owns the timer 1 flag
  assign ovf1_evt = (mode0 == MODE_SPLIT) ? (th0_split_inc && th0_split_ovf) : t1_step.ovf; // see RULE9

  // external interrupt edge events: falling edge only, low level is taken in the flag logic
  logic [1:0] irq_edge;
  assign irq_edge = irq_level_d_reg & ~pin_level[1:0];

  // delayed irq levels for edge detection on every clock
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      irq_level_d_reg <= 2'b11;
    else
      irq_level_d_reg <= pin_level[1:0];
  end

  // mode register: plain software storage
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      timer_mode_config_reg <= `DTC_MODE_RESET;
    else if (wr_timer_mode_config)
      timer_mode_config_reg <= sfr_wdata;
  end

  // timer 0 bytes; a software write wins over a count in the same cycle
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tl0_reg <= `DTC_COUNT_RESET;
      th0_reg <= `DTC_COUNT_RESET;
    end
    else
    begin
      tl0_reg <= wr_tl0 ? sfr_wdata : t0_step.lo;  // see RULE18
      if (wr_th0)
        th0_reg <= sfr_wdata;
      else if (mode0 == MODE_SPLIT)
        th0_reg <= th0_split_inc ? th0_split_val : th0_reg;
      else
        th0_reg <= t0_step.hi;                     // see RULE18
    end
  end

  // timer 1 bytes; held still in mode 11 since run1 is low there
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tl1_reg <= `DTC_COUNT_RESET;
      th1_reg <= `DTC_COUNT_RESET;
    end
    else
    begin
      tl1_reg <= wr_tl1 ? sfr_wdata : t1_step.lo;  // see RULE8
      th1_reg <= wr_th1 ? sfr_wdata : t1_step.hi;
    end
  end

  // run and trigger-type bits: software only
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tr1_reg <= 1'b0;                              // see RULE17
      tr0_reg <= 1'b0;
      it1_reg <= 1'b0;
      it0_reg <= 1'b0;
    end
    else if (wr_timer_control)
    begin
      tr1_reg <= sfr_wdata[`DTC_TR1_BIT];
      tr0_reg <= sfr_wdata[`DTC_TR0_BIT];
      it1_reg <= sfr_wdata[`DTC_IT1_BIT];
      it0_reg <= sfr_wdata[`DTC_IT0_BIT];
    end
  end

  // overflow flags: hardware set first, then vector clear, then software
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tf1_reg <= 1'b0;                              // see RULE17
      tf0_reg <= 1'b0;
    end
    else
    begin
      if (ovf1_evt)
        tf1_reg <= 1'b1;                            // see RULE10 see RULE23
      else if (vector_ack.tf1)
        tf1_reg <= 1'b0;                            // see RULE11
      else if (wr_timer_control)
        tf1_reg <= sfr_wdata[`DTC_TF1_BIT];
      if (ovf0_evt)
        tf0_reg <= 1'b1;                            // see RULE10 see RULE23
      else if (vector_ack.tf0)
        tf0_reg <= 1'b0;                            // see RULE11
      else if (wr_timer_control)
        tf0_reg <= sfr_wdata[`DTC_TF0_BIT];
    end
  end

  // external flags; in level mode the flag is simply the inverted pin,
  // so vector acks and software writes cannot hold a request the pin dropped
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ie1_reg <= 1'b0;                              // see RULE17
      ie0_reg <= 1'b0;
    end
    else
    begin
      if (!it1_reg)
        ie1_reg <= !pin_level[1];                   // see RULE14 see RULE15
      else if (irq_edge[1])
        ie1_reg <= 1'b1;                            // see RULE13 see RULE23
      else if (vector_ack.ie1)
        ie1_reg <= 1'b0;                            // see RULE14
      else if (wr_timer_control)
        ie1_reg <= sfr_wdata[`DTC_IE1_BIT];
      if (!it0_reg)
        ie0_reg <= !pin_level[0];                   // see RULE14 see RULE15
      else if (irq_edge[0])
        ie0_reg <= 1'b1;                            // see RULE13 see RULE23
      else if (vector_ack.ie0)
        ie0_reg <= 1'b0;                            // see RULE14
      else if (wr_timer_control)
        ie0_reg <= sfr_wdata[`DTC_IE0_BIT];
    end
  end

  // registered read port; unmapped addresses answer zero
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      sfr_rdata <= 8'h00;
    else if (sfr_rd_en)
    begin
      unique case (sfr_addr)
        `DTC_ADDR_CONTROL: sfr_rdata <= timer_control_reg;
        `DTC_ADDR_MODE:    sfr_rdata <= timer_mode_config_reg;
        `DTC_ADDR_T0_LOW:  sfr_rdata <= tl0_reg;
        `DTC_ADDR_T1_LOW:  sfr_rdata <= tl1_reg;
        `DTC_ADDR_T0_HIGH: sfr_rdata <= th0_reg;
        `DTC_ADDR_T1_HIGH: sfr_rdata <= th1_reg;
        default:           sfr_rdata <= 8'h00;
      endcase
    end
  end

  // flags toward the interrupt controller come straight from timer_control_reg
  assign irq_flags = '{tf1: timer_control_reg[`DTC_TF1_BIT], tf0: timer_control_reg[`DTC_TF0_BIT],
                       ie1: timer_control_reg[`DTC_IE1_BIT], ie0: timer_control_reg[`DTC_IE0_BIT]};

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic no_t0_wr;
  assign no_t0_wr = !wr_tl0 && !wr_th0;

  property p_gate_hold;
    (timer_mode_config_reg[`DTC_GATE0_BIT] && !pin_level[0] && mode0 != MODE_SPLIT && no_t0_wr) |=> $stable({th0_reg, tl0_reg});
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gated timer 0 moved while pin low"); // see RULE1

  property p_run_stop;
    (!timer_control_reg[`DTC_TR0_BIT] && mode0 != MODE_SPLIT && no_t0_wr) |=> $stable({th0_reg, tl0_reg});
  endproperty
  a_run_stop: assert property (p_run_stop) else $error("stopped timer 0 moved"); // see RULE12

  property p_mc_count;
    (mode0 == MODE_16BIT && run0 && !timer_mode_config_reg[`DTC_CT0_BIT] && mc_tick && no_t0_wr && tl0_reg != 8'hFF)
      |=> (tl0_reg == $past(tl0_reg) + 8'h01) ##1 $stable(tl0_reg) [*2];
  endproperty
  a_mc_count: assert property (p_mc_count) else $error("timer 0 did not advance once per cycle"); // see RULE19

  property p_reload;
    (mode0 == MODE_RELOAD && run0 && src0 && tl0_reg == 8'hFF && no_t0_wr)
      |=> (tl0_reg == $past(th0_reg)) && $stable(th0_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("reload value wrong"); // see RULE7

  property p_prescale;
    (mode0 == MODE_13BIT && run0 && src0 && tl0_reg[4:0] == 5'h1F && no_t0_wr)
      |=> (th0_reg == $past(th0_reg) + 8'h01) && (tl0_reg[7:5] == $past(tl0_reg[7:5]));
  endproperty
  a_prescale: assert property (p_prescale) else $error("13-bit carry wrong"); // see RULE21

  property p_ovf_set;
    ovf0_evt |=> irq_flags.tf0;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set"); // see RULE23

  property p_ack_clear;
    (vector_ack.tf0 && !ovf0_evt) |=> !irq_flags.tf0;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("overflow flag not cleared on vector"); // see RULE11

  property p_t1_frozen;
    (mode1 == MODE_SPLIT && !wr_tl1 && !wr_th1) |=> $stable({th1_reg, tl1_reg});
  endproperty
  a_t1_frozen: assert property (p_t1_frozen) else $error("timer 1 moved in mode 11"); // see RULE8

  property p_level_follow;
    !timer_control_reg[`DTC_IT0_BIT] |=> (irq_flags.ie0 == !$past(pin_level[0]));
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("level flag not following pin"); // see RULE14

  property p_edge_set;
    (timer_control_reg[`DTC_IT0_BIT] && irq_edge[0]) |=> irq_flags.ie0;
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge flag not set"); // see RULE13

  property p_reset_zero;
    @(posedge clk) disable iff (1'b0) !reset_n |=> (timer_control_reg == `DTC_CONTROL_RESET);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("control not zero after reset"); // see RULE17

  c_mode0_ovf:  cover property (mode0 == MODE_13BIT && ovf0_evt);
  c_reload:     cover property (mode0 == MODE_RELOAD && ovf0_evt);
  c_split_tf1:  cover property (mode0 == MODE_SPLIT && ovf1_evt);
  c_edge_irq:   cover property (timer_control_reg[`DTC_IT1_BIT] && irq_edge[1]);

endmodule
`default_nettype wire

/* File: machine_cycle_gen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dtc_regs.svh"

module machine_cycle_gen #(
  parameter int unsigned MC_CLOCKS = `DTC_MC_CLOCKS
) (
  input  wire logic clk,
  input  wire logic reset_n,
  output logic      mc_tick
);

  // phase counter inside one machine cycle
  logic [3:0] phase_reg;

  // wrap after the last core clock of the cycle
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      phase_reg <= 4'h0;
    else if (phase_reg == 4'(MC_CLOCKS - 1))
      phase_reg <= 4'h0;
    else
      phase_reg <= phase_reg + 4'h1;
  end

  // one-clock pulse that marks the machine cycle boundary
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      mc_tick <= 1'b0;
    else
      mc_tick <= (phase_reg == 4'(MC_CLOCKS - 2)); // see RULE19
  end

endmodule
`default_nettype wire

/* File: pin_sampler.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_sampler #(
  parameter int unsigned W = 4
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         mc_tick,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level,
  output logic      [W-1:0] fall
);

  // first stage is read only by the second stage
  logic [W-1:0] meta_reg;
  // sample taken at the previous machine cycle boundary
  logic [W-1:0] prev_reg;

  // two-flop synchroniser; pins idle high
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      meta_reg <= '1;
      level    <= '1;
    end
    else
    begin
      meta_reg <= pin;
      level    <= meta_reg;
    end
  end

  // once per machine cycle: high then low gives one event pulse
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      prev_reg <= '1;
      fall     <= '0;
    end
    else if (mc_tick)
    begin
      prev_reg <= level;
      fall     <= prev_reg & ~level;
    end
    else
      fall <= '0;
  end

endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dtc_regs.svh"

module tb_top;
  import dtc_pkg::*;
  localparam int MC = 4;             // shortened machine cycle keeps the run brief
  localparam int HOLD = 2 * MC + 3;  // each pin level spans two machine cycles plus sync delay
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_wr_en = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        sfr_rd_en = 1'b0;
  logic [7:0]  sfr_rdata;
  logic        t0_in, t1_in, irq0, irq1;
  vector_ack_t vector_ack = '0;
  irq_flags_t  irq_flags;
  int          mismatches = 0;
  int          tests_run = 0;

  always #4 clk = ~clk;

  dual_timer_counter_control #(.MC_CLOCKS(MC)) dut (
    .clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
    .sfr_wdata(sfr_wdata), .sfr_rd_en(sfr_rd_en), .sfr_rdata(sfr_rdata),
    .ext_irq0_pin(irq0), .ext_irq1_pin(irq1), .timer0_count_input(t0_in),
    .timer1_count_input(t1_in), .vector_ack(vector_ack), .irq_flags(irq_flags));

  count_pin_model #(.HOLD(HOLD)) pins (
    .clk(clk), .timer0_count_input(t0_in), .timer1_count_input(t1_in),
    .ext_irq0_pin(irq0), .ext_irq1_pin(irq1));

  // verdict in one place
  task automatic final_report();
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // compare seen against expected; case inequality so X never matches
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr_en <= 1'b1;
    @(posedge clk);
    sfr_wr_en <= 1'b0;
  endtask

  // data is registered: taken one cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd_en <= 1'b1;
    @(posedge clk);
    sfr_rd_en <= 1'b0;
    #1 d = sfr_rdata;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask

  // tick phase is free-running, so timed counts are judged within a window
  task automatic chk_rng(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] d;
    rd(a, d);
    check({7'h0, (d >= lo) && (d <= hi)}, 8'h01);
  endtask

  // bounded wait on one flag; running out of patience ends the run
  task automatic wait_flag(input int idx, input logic val, input int max);
    int n;
    n = 0;
    while (irq_flags[idx] !== val && n < max)
    begin
      @(posedge clk);
      #1 n++;
    end
    check({7'h0, irq_flags[idx]}, {7'h0, val});
    if (irq_flags[idx] !== val) final_report();
  endtask

  // one-cycle vector pulse, flag must be gone right after
  task automatic ack(input vector_ack_t a, input int idx);
    @(posedge clk);
    vector_ack <= a;
    @(posedge clk);
    vector_ack <= '0;
    #1 check({7'h0, irq_flags[idx]}, 8'h00);
  endtask

  task automatic t_reset();
    chk_rd(`DTC_ADDR_CONTROL, 8'h00);
    chk_rd(`DTC_ADDR_MODE, 8'h00);
    chk_rd(`DTC_ADDR_T0_LOW, 8'h00);
    chk_rd(8'h90, 8'h00);
    wr(8'h90, 8'hFF);
    chk_rd(8'h90, 8'h00);
  endtask

  task automatic t_sw_flags();
    wr(`DTC_ADDR_CONTROL, 8'hA0);
    chk_rd(`DTC_ADDR_CONTROL, 8'hA0);
    check({4'h0, irq_flags}, 8'h0C);
    wr(`DTC_ADDR_CONTROL, 8'h00);
  endtask

  // 16-bit roll from ffff to 0000 sets the flag, vectoring clears it
  task automatic t_mode1();
    wr(`DTC_ADDR_MODE, 8'h01);
    wr(`DTC_ADDR_T0_LOW, 8'hFE);
    wr(`DTC_ADDR_T0_HIGH, 8'hFF);
    wr(`DTC_ADDR_CONTROL, 8'h10);
    wait_flag(2, 1'b1, 3 * MC + 8);
    ack(4'b0100, 2);
    wr(`DTC_ADDR_CONTROL, 8'h00);
    chk_rd(`DTC_ADDR_T0_HIGH, 8'h00);
  endtask

  // 13-bit roll: high byte wraps after low five bits, upper three left alone
  task automatic t_mode0();
    logic [7:0] d;
    wr(`DTC_ADDR_MODE, 8'h00);
    wr(`DTC_ADDR_T0_LOW, 8'hFF);
    wr(`DTC_ADDR_T0_HIGH, 8'hFF);
    wr(`DTC_ADDR_CONTROL, 8'h10);
    wait_flag(2, 1'b1, 2 * MC + 8);
    wr(`DTC_ADDR_CONTROL, 8'h00);
    chk_rd(`DTC_ADDR_T0_HIGH, 8'h00);
    rd(`DTC_ADDR_T0_LOW, d);
    check({5'h0, d[7:5]}, 8'h07);
  endtask

  // auto reload of timer 1 low byte from an unchanging high byte
  task automatic t_reload();
    wr(`DTC_ADDR_MODE, 8'h20);
    wr(`DTC_ADDR_T1_HIGH, 8'hA0);
    wr(`DTC_ADDR_T1_LOW, 8'hFE);
    wr(`DTC_ADDR_CONTROL, 8'h40);
    wait_flag(3, 1'b1, 3 * MC + 8);
    chk_rng(`DTC_ADDR_T1_LOW, 8'hA0, 8'hA2);
    chk_rd(`DTC_ADDR_T1_HIGH, 8'hA0);
    wr(`DTC_ADDR_CONTROL, 8'h00);
  endtask

  // timer 1 in mode 11 holds even with its run bit set
  task automatic t_t1_stop();
    wr(`DTC_ADDR_MODE, 8'h30);
    wr(`DTC_ADDR_T1_LOW, 8'h55);
    wr(`DTC_ADDR_CONTROL, 8'h40);
    repeat (6 * MC) @(posedge clk);
    chk_rd(`DTC_ADDR_T1_LOW, 8'h55);
    wr(`DTC_ADDR_CONTROL, 8'h00);
  endtask

  // split mode: timer 0 high byte runs on timer 1 run bit and raises its flag
  task automatic t_split();
    wr(`DTC_ADDR_MODE, 8'h03);
    wr(`DTC_ADDR_T0_LOW, 8'h10);
    wr(`DTC_ADDR_T0_HIGH, 8'hFE);
    wr(`DTC_ADDR_CONTROL, 8'h40);
    wait_flag(3, 1'b1, 3 * MC + 8);
    check({7'h0, irq_flags.tf0}, 8'h00);
    chk_rd(`DTC_ADDR_T0_LOW, 8'h10);
    wr(`DTC_ADDR_CONTROL, 8'h00);
  endtask

  // gating on the interrupt pin, plus rate of one step per machine cycle
  task automatic t_gate();
    wr(`DTC_ADDR_MODE, 8'h09);
    wr(`DTC_ADDR_T0_LOW, 8'h00);
    pins.irq(0, 1'b0);
    wr(`DTC_ADDR_CONTROL, 8'h11);
    repeat (10 * MC) @(posedge clk);
    chk_rd(`DTC_ADDR_T0_LOW, 8'h00);
    wr(`DTC_ADDR_CONTROL, 8'h00);
    pins.irq(0, 1'b1);
    wr(`DTC_ADDR_CONTROL, 8'h11);
    repeat (10 * MC) @(posedge clk);
    wr(`DTC_ADDR_CONTROL, 8'h01);
    chk_rng(`DTC_ADDR_T0_LOW, 8'd9, 8'd12);
    wr(`DTC_ADDR_MODE, 8'h01);
    wr(`DTC_ADDR_T0_LOW, 8'h00);
    pins.irq(0, 1'b0);
    wr(`DTC_ADDR_CONTROL, 8'h10);
    repeat (10 * MC) @(posedge clk);
    wr(`DTC_ADDR_CONTROL, 8'h00);
    chk_rng(`DTC_ADDR_T0_LOW, 8'd9, 8'd12);
    chk_rng(`DTC_ADDR_T0_LOW, 8'd9, 8'd12);
    pins.irq(0, 1'b1);
  endtask

  // counter function: exactly one step per fall, none from the internal tick
  task automatic t_counter();
    wr(`DTC_ADDR_MODE, 8'h45);
    wr(`DTC_ADDR_T0_LOW, 8'h00);
    wr(`DTC_ADDR_T1_LOW, 8'h00);
    wr(`DTC_ADDR_CONTROL, 8'h50);
    pins.pulse(0, 3);
    pins.pulse(1, 2);
    repeat (2 * MC + 4) @(posedge clk);
    chk_rd(`DTC_ADDR_T0_LOW, 8'h03);
    chk_rd(`DTC_ADDR_T1_LOW, 8'h02);
    wr(`DTC_ADDR_CONTROL, 8'h00);
  endtask

  // both interrupt pins in edge and level mode
  task automatic t_ext_irq();
    for (int i = 0; i < 2; i++)
    begin
      wr(`DTC_ADDR_CONTROL, (i == 0) ? 8'h01 : 8'h04);
      pins.irq(i, 1'b0);
      wait_flag(i, 1'b1, 8);
      pins.irq(i, 1'b1);
      repeat (8) @(posedge clk);
      #1 check({7'h0, irq_flags[i]}, 8'h01);
      ack((i == 0) ? 4'b0001 : 4'b0010, i);
      wr(`DTC_ADDR_CONTROL, 8'h00);
      pins.irq(i, 1'b0);
      wait_flag(i, 1'b1, 8);
      pins.irq(i, 1'b1);
      wait_flag(i, 1'b0, 8);
    end
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_sw_flags();
    t_mode1();
    t_mode0();
    t_reload();
    t_t1_stop();
    t_split();
    t_gate();
    t_counter();
    t_ext_irq();
    final_report();
  end
endmodule

`default_nettype wire
